/* core/cis_pkg.sv */
// Purpose: constants and types of the instruction subset execution core
// Assumes: one 200 MHz clock, byte wide program memory with same-cycle read data
// Notes: cycle counts are totals per instruction, opcode fetch included
// What this block does
// - opcode 97 copies accumulator to index in two cycles, flags untouched
// - opcode 9F copies index to accumulator in two cycles, flags untouched
// - test sets N and Z from operand only; 3D,4D,5D,6D,7D take 4,3,3,5,4
// - opcode 83 pushes PC low, PC high, X, A, flags; sets I; loads vector
// - byte offset indexed address is index plus one unsigned byte
// - word offset indexed address is index plus high-then-low offset bytes
// - plain indexed mode uses the index register as address, no operand
// - full address mode fetches high then low address byte after opcode
// - bit branch carries direct address then signed displacement, PC relative
// - operand field is none, one or two bytes as the addressing mode says
package cis_pkg;
  localparam int AW = 16;
  // opcodes and opcode rows
  localparam logic [7:0] OPC_ACC_TO_INDEX = 8'h97;
  localparam logic [7:0] OPC_INDEX_TO_ACC = 8'h9F;
  localparam logic [7:0] OPC_TRAP = 8'h83;
  localparam logic [7:0] OPC_PAUSE = 8'h8F;
  localparam logic [3:0] SUB_COL = 4'h0;
  localparam logic [3:0] TEST_COL = 4'hD;
  localparam logic [3:0] ROW_BITBR = 4'h0;
  localparam logic [3:0] ROW_ACC = 4'h4;
  // cycle counts, fetch included
  localparam logic [3:0] CYC_SUB_LIT = 4'h2;
  localparam logic [3:0] CYC_SUB_DIR = 4'h3;
  localparam logic [3:0] CYC_SUB_FULL = 4'h4;
  localparam logic [3:0] CYC_SUB_IDXW = 4'h5;
  localparam logic [3:0] CYC_SUB_IDXB = 4'h4;
  localparam logic [3:0] CYC_SUB_IDXP = 4'h3;
  localparam logic [3:0] CYC_TEST_DIR = 4'h4;
  localparam logic [3:0] CYC_TEST_REG = 4'h3;
  localparam logic [3:0] CYC_TEST_IDXB = 4'h5;
  localparam logic [3:0] CYC_TEST_IDXP = 4'h4;
  localparam logic [3:0] CYC_COPY = 4'h2;
  localparam logic [3:0] CYC_TRAP = 4'hA;
  localparam logic [3:0] CYC_PAUSE = 4'h2;
  localparam logic [3:0] CYC_BITBR = 4'h5;
  // flag register layout and reset values
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam logic [7:0] FLAGS_RST = 8'hE8;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [15:0] VEC_RST = 16'hFFFC;
  localparam logic [2:0] PUSH_LAST = 3'h4;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_INDEX = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_PC = 8'h14;
  localparam logic [7:0] REG_SP = 8'h18;
  localparam logic [7:0] REG_VEC = 8'h1C;
  localparam int CTRL_RUN = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SLEEP = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_OPC_LSB = 8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_FETCH = 4'h1, ST_OPND1 = 4'h2, ST_OPND2 = 4'h3,
    ST_READ = 4'h4, ST_EXEC = 4'h5, ST_PUSH = 4'h6, ST_VECA = 4'h7,
    ST_VECH = 4'h8, ST_VECL = 4'h9, ST_PAD = 4'hA, ST_SLEEP = 4'hB
  } cis_state_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_SUB = 3'h1, OP_TEST = 3'h2, OP_BITBR = 3'h3,
    OP_TRAP = 3'h4, OP_ACC_TO_INDEX = 3'h5, OP_INDEX_TO_ACC = 3'h6, OP_PAUSE = 3'h7
  } cis_op_t;
  typedef enum logic [2:0] {
    IMPLIED_OPERAND_MODE = 3'h0, LITERAL_OPERAND_MODE = 3'h1, DIRECT_MODE = 3'h2,
    FULL_ADDRESS_MODE = 3'h3, INDEX_WORD_OFFSET_MODE = 3'h4,
    INDEX_BYTE_OFFSET_MODE = 3'h5, INDEX_PLAIN_MODE = 3'h6, BIT_BRANCH_MODE = 3'h7
  } cis_mode_t;
  typedef struct packed {
    cis_op_t op;
    cis_mode_t mode;
    logic [3:0] cnt;
  } cis_dec_t;
endpackage

/* core/cis_core.sv */
// Purpose: executes subtract, test, bit branch, trap, copies and pause
// Assumes: mem_rdata is valid in the cycle mem_addr stands; AHB-Lite word access
// Notes: software loads the core state while stopped, then sets the run bit
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cis_core (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // program and data memory
  output logic [cis_pkg::AW-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // wake and status
  input wire logic wake_irq,
  output logic cpu_halted,
  output logic core_busy
);
  import cis_pkg::*;

  typedef struct packed {
    cis_state_t st;
    logic [3:0] cyc;
    cis_op_t op;
    cis_mode_t mode;
    logic [3:0] cnt;
    logic [7:0] opc;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [7:0] flag_register;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] vec;
    logic [7:0] hi;
    logic [7:0] rel;
    logic [2:0] pidx;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_wr;
    logic mem_rd;
    logic run;
    logic err;
    logic dph_v;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic rdwait;
    logic [31:0] hrdata;
  } cis_regs_t;

  localparam cis_regs_t REGS_RST = '{
    st: ST_IDLE, op: OP_NONE, mode: IMPLIED_OPERAND_MODE,
    flag_register: FLAGS_RST, sp: SP_RST, vec: VEC_RST, default: '0
  };

  cis_regs_t r_q;
  cis_regs_t r_d;
  cis_dec_t dec;
  logic err_set;
  logic tbit;

  // opcode decode: class, addressing mode and total cycle count
  function automatic cis_dec_t decode(input logic [7:0] o);
    cis_dec_t d;
    d.op = OP_NONE;
    d.mode = IMPLIED_OPERAND_MODE;
    d.cnt = CYC_COPY;
    if (o[3:0] == SUB_COL && o[7:4] >= 4'hA) begin
      d.op = OP_SUB;
      case (o[7:4])
        4'hA: begin
          d.mode = LITERAL_OPERAND_MODE;
          d.cnt = CYC_SUB_LIT;
        end
        4'hB: begin
          d.mode = DIRECT_MODE;
          d.cnt = CYC_SUB_DIR;
        end
        4'hC: begin
          d.mode = FULL_ADDRESS_MODE;
          d.cnt = CYC_SUB_FULL;
        end
        4'hD: begin
          d.mode = INDEX_WORD_OFFSET_MODE;
          d.cnt = CYC_SUB_IDXW;
        end
        4'hE: begin
          d.mode = INDEX_BYTE_OFFSET_MODE;
          d.cnt = CYC_SUB_IDXB;
        end
        default: begin
          d.mode = INDEX_PLAIN_MODE;
          d.cnt = CYC_SUB_IDXP;
        end
      endcase
    end else if (o[3:0] == TEST_COL && o[7:4] >= 4'h3 && o[7:4] <= 4'h7) begin
      d.op = OP_TEST;
      case (o[7:4])
        4'h3: begin
          d.mode = DIRECT_MODE;
          d.cnt = CYC_TEST_DIR;
        end
        4'h6: begin
          d.mode = INDEX_BYTE_OFFSET_MODE;
          d.cnt = CYC_TEST_IDXB;
        end
        4'h7: begin
          d.mode = INDEX_PLAIN_MODE;
          d.cnt = CYC_TEST_IDXP;
        end
        default: d.cnt = CYC_TEST_REG;
      endcase
    end else if (o[7:4] == ROW_BITBR) begin
      d.op = OP_BITBR;
      d.mode = BIT_BRANCH_MODE;
      d.cnt = CYC_BITBR;
    end else begin
      case (o)
        OPC_ACC_TO_INDEX: d.op = OP_ACC_TO_INDEX;
        OPC_INDEX_TO_ACC: d.op = OP_INDEX_TO_ACC;
        OPC_TRAP: begin
          d.op = OP_TRAP;
          d.cnt = CYC_TRAP;
        end
        OPC_PAUSE: begin
          d.op = OP_PAUSE;
          d.cnt = CYC_PAUSE;
        end
        default: d.op = OP_NONE;
      endcase
    end
    return d;
  endfunction

  // subtract or test on an operand byte
  function automatic cis_regs_t apply_alu(input cis_regs_t s, input logic [7:0] m);
    cis_regs_t t;
    logic [8:0] diff;
    t = s;
    diff = {1'b0, s.acc} - {1'b0, m};
    if (s.op == OP_SUB) begin
      t.acc = diff[7:0];
      t.flag_register[FLG_C] = diff[8];
      t.flag_register[FLG_N] = diff[7];
      t.flag_register[FLG_Z] = (diff[7:0] == 8'h00);
    end else begin
      // operand minus zero: only N and Z move, operand is never written back
      t.flag_register[FLG_N] = m[7];
      t.flag_register[FLG_Z] = (m == 8'h00);
    end
    return t;
  endfunction

  // end of an instruction: pad up to its cycle count, then fetch or stop
  function automatic cis_regs_t end_instr(input cis_regs_t s, input logic [3:0] c);
    cis_regs_t t;
    t = s;
    t.mem_addr = s.pc;
    t.mem_wr = 1'b0;
    if (s.op == OP_PAUSE) begin
      t.st = ST_SLEEP;
    end else if (c >= s.cnt - 4'h1) begin
      t.st = s.run ? ST_FETCH : ST_IDLE;
    end else begin
      t.st = ST_PAD;
    end
    t.mem_rd = (t.st == ST_FETCH);
    return t;
  endfunction

  // register read mux; unmapped offsets read as zero
  function automatic logic [31:0] rd_word(input cis_regs_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      REG_CTRL: w[CTRL_RUN] = s.run;
      REG_STATUS: begin
        w[STAT_BUSY] = (s.st != ST_IDLE);
        w[STAT_SLEEP] = (s.st == ST_SLEEP);
        w[STAT_ERR] = s.err;
        w[STAT_OPC_LSB +: 8] = s.opc;
      end
      REG_ACC: w[7:0] = s.acc;
      REG_INDEX: w[7:0] = s.idx;
      REG_FLAGS: w[7:0] = s.flag_register;
      REG_PC: w[15:0] = s.pc;
      REG_SP: w[15:0] = s.sp;
      REG_VEC: w[15:0] = s.vec;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // next state of the whole block
  always_comb begin
    r_d = r_q;
    dec = decode(mem_rdata);
    err_set = 1'b0;
    tbit = mem_rdata[r_q.opc[3:1]];
    r_d.mem_wr = 1'b0;
    r_d.mem_rd = 1'b0;
    r_d.cyc = (r_q.cyc == 4'hF) ? r_q.cyc : r_q.cyc + 4'h1;
    case (r_q.st)
      ST_IDLE: begin
        r_d.mem_addr = r_q.pc;
        if (r_q.run) begin
          r_d.st = ST_FETCH;
          r_d.mem_rd = 1'b1;
        end
      end
      ST_FETCH: begin
        r_d.opc = mem_rdata;
        r_d.op = dec.op;
        r_d.mode = dec.mode;
        r_d.cnt = dec.cnt;
        r_d.cyc = 4'h1;
        r_d.pc = r_q.pc + 16'h0001;
        r_d.mem_addr = r_d.pc;
        r_d.mem_rd = 1'b1;
        r_d.pidx = 3'h0;
        case (dec.mode)
          IMPLIED_OPERAND_MODE: begin
            r_d.st = (dec.op == OP_TRAP) ? ST_PUSH : ST_EXEC;
            r_d.mem_rd = 1'b0;
          end
          INDEX_PLAIN_MODE: begin
            r_d.mem_addr = {8'h00, r_q.idx};
            r_d.st = ST_READ;
          end
          default: r_d.st = ST_OPND1;
        endcase
        // unknown opcode stops the core and flags it
        if (dec.op == OP_NONE) begin
          r_d.st = ST_IDLE;
          r_d.run = 1'b0;
          r_d.mem_rd = 1'b0;
          err_set = 1'b1;
        end
      end
      ST_OPND1: begin
        r_d.pc = r_q.pc + 16'h0001;
        r_d.mem_rd = 1'b1;
        r_d.st = ST_READ;
        case (r_q.mode)
          LITERAL_OPERAND_MODE: r_d = end_instr(apply_alu(r_d, mem_rdata), r_q.cyc);
          DIRECT_MODE: r_d.mem_addr = {8'h00, mem_rdata};
          INDEX_BYTE_OFFSET_MODE: r_d.mem_addr = {8'h00, r_q.idx} + {8'h00, mem_rdata};
          default: begin
            r_d.hi = mem_rdata;
            r_d.mem_addr = r_d.pc;
            r_d.st = ST_OPND2;
          end
        endcase
      end
      ST_OPND2: begin
        r_d.pc = r_q.pc + 16'h0001;
        r_d.mem_rd = 1'b1;
        r_d.st = ST_READ;
        case (r_q.mode)
          FULL_ADDRESS_MODE: r_d.mem_addr = {r_q.hi, mem_rdata};
          INDEX_WORD_OFFSET_MODE: r_d.mem_addr = {r_q.hi, mem_rdata} + {8'h00, r_q.idx};
          default: begin
            r_d.rel = mem_rdata;
            r_d.mem_addr = {8'h00, r_q.hi};
          end
        endcase
      end
      ST_READ: begin
        if (r_q.op == OP_BITBR) begin
          // even opcodes branch on a set bit, odd ones on a clear bit
          r_d.flag_register[FLG_C] = tbit;
          if (tbit ^ r_q.opc[0]) begin
            r_d.pc = r_q.pc + {{8{r_q.rel[7]}}, r_q.rel};
          end
        end else begin
          r_d = apply_alu(r_d, mem_rdata);
        end
        r_d = end_instr(r_d, r_q.cyc);
      end
      ST_EXEC: begin
        case (r_q.op)
          OP_ACC_TO_INDEX: r_d.idx = r_q.acc;
          OP_INDEX_TO_ACC: r_d.acc = r_q.idx;
          OP_PAUSE: r_d.flag_register[FLG_I] = 1'b0;
          OP_TEST: r_d = apply_alu(r_d, (r_q.opc[7:4] == ROW_ACC) ? r_q.acc : r_q.idx);
          default: r_d.st = ST_IDLE;
        endcase
        r_d = end_instr(r_d, r_q.cyc);
      end
      ST_PUSH: begin
        // one stack write per cycle, stack pointer drops after each
        r_d.mem_addr = r_q.sp;
        r_d.mem_wr = 1'b1;
        r_d.sp = r_q.sp - 16'h0001;
        r_d.pidx = r_q.pidx + 3'h1;
        case (r_q.pidx)
          3'h0: r_d.mem_wdata = r_q.pc[7:0];
          3'h1: r_d.mem_wdata = r_q.pc[15:8];
          3'h2: r_d.mem_wdata = r_q.idx;
          3'h3: r_d.mem_wdata = r_q.acc;
          default: r_d.mem_wdata = r_q.flag_register;
        endcase
        if (r_q.pidx == PUSH_LAST) begin
          r_d.st = ST_VECA;
        end
      end
      ST_VECA: begin
        r_d.flag_register[FLG_I] = 1'b1;
        r_d.mem_addr = r_q.vec;
        r_d.mem_rd = 1'b1;
        r_d.st = ST_VECH;
      end
      ST_VECH: begin
        r_d.pc[15:8] = mem_rdata;
        r_d.mem_addr = r_q.vec + 16'h0001;
        r_d.mem_rd = 1'b1;
        r_d.st = ST_VECL;
      end
      ST_VECL: begin
        r_d.pc[7:0] = mem_rdata;
        r_d = end_instr(r_d, r_q.cyc);
      end
      ST_PAD: r_d = end_instr(r_d, r_q.cyc);
      ST_SLEEP: begin
        // the core stays frozen until a wake request; reset also ends it
        r_d.mem_addr = r_q.pc;
        if (wake_irq) begin
          r_d.st = r_q.run ? ST_FETCH : ST_IDLE;
          r_d.mem_rd = r_q.run;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase

    // bus address phase, taken only while the bus is ready
    if (hready) begin
      r_d.dph_v = hsel && htrans[1];
      r_d.dph_wr = hwrite;
      r_d.dph_addr = {haddr[7:2], 2'b00};
    end
    // reads take one wait state so that hrdata comes from a flop
    r_d.rdwait = r_q.dph_v && !r_q.dph_wr && !r_q.rdwait;
    if (r_d.rdwait) begin
      r_d.hrdata = rd_word(r_q, r_q.dph_addr);
    end
    // bus data phase writes; core state is writable only while stopped
    if (r_q.dph_v && r_q.dph_wr) begin
      case (r_q.dph_addr)
        REG_CTRL: r_d.run = hwdata[CTRL_RUN];
        REG_STATUS: if (hwdata[STAT_ERR]) r_d.err = 1'b0;
        REG_ACC: if (r_q.st == ST_IDLE) r_d.acc = hwdata[7:0];
        REG_INDEX: if (r_q.st == ST_IDLE) r_d.idx = hwdata[7:0];
        REG_FLAGS: if (r_q.st == ST_IDLE) r_d.flag_register = hwdata[7:0];
        REG_PC: if (r_q.st == ST_IDLE) r_d.pc = hwdata[15:0];
        REG_SP: if (r_q.st == ST_IDLE) r_d.sp = hwdata[15:0];
        REG_VEC: if (r_q.st == ST_IDLE) r_d.vec = hwdata[15:0];
        default: r_d.err = r_d.err;
      endcase
    end
    // a fault in the same cycle as its clear still lands
    if (err_set) begin
      r_d.err = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs
  assign hreadyout = !(r_q.dph_v && !r_q.dph_wr && !r_q.rdwait);
  assign hresp = 1'b0;
  assign hrdata = r_q.hrdata;
  assign mem_addr = r_q.mem_addr;
  assign mem_rd = r_q.mem_rd;
  assign mem_wr = r_q.mem_wr;
  assign mem_wdata = r_q.mem_wdata;
  assign cpu_halted = (r_q.st == ST_SLEEP);
  assign core_busy = (r_q.st != ST_IDLE);

endmodule
`default_nettype wire

/* test/cis_core_sva.sv */
// Purpose: concurrent checks on the memory and pause side of the subset core
// Assumes: the bench keeps only opcodes and small operand bytes in 0x0400-0x07FF
// Notes: a fetch is recognised by that window, so data reads never start a check
`timescale 1ns/10ps
`default_nettype none
module cis_core_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // memory side
  input wire logic [cis_pkg::AW-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // pause and status
  input wire logic wake_irq,
  input wire logic cpu_halted,
  input wire logic core_busy
);
  import cis_pkg::*;
  logic fet;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // opcode fetch inside the program window
  assign fet = mem_rd && core_busy && mem_addr[15:10] == 6'h01;
  // five pushes back to back, then the stack stops
  sequence push_s;
    mem_wr [*5] ##1 !mem_wr;
  endsequence
  // a push one byte below the one before it; trap_frame_a checks this on the second push only
  sequence sp_dec_s;
    mem_wr && mem_addr == $past(mem_addr) - 16'h0001;
  endsequence
  copy_len_a:
    assert property (fet && (mem_rdata == OPC_ACC_TO_INDEX || mem_rdata == OPC_INDEX_TO_ACC)
      |-> ##2 mem_rd && mem_addr == $past(mem_addr, 2) + 16'h0001) else $error("copy length wrong");
  trap_push_a:
    assert property (fet && mem_rdata == OPC_TRAP |-> ##2 push_s) else $error("trap push count wrong");
  trap_frame_a:
    assert property (fet && mem_rdata == OPC_TRAP |-> ##2 mem_wdata == 8'($past(mem_addr, 2) + 16'h0001)
      ##1 sp_dec_s) else $error("trap frame wrong");
  trap_vec_a:
    assert property (fet && mem_rdata == OPC_TRAP |-> ##7 mem_rd
      ##1 mem_rd && mem_addr == $past(mem_addr) + 16'h0001 ##2 mem_rd) else $error("trap vector timing wrong");
  test_len_a:
    assert property (fet && (mem_rdata == 8'h4D || mem_rdata == 8'h5D)
      |-> ##3 mem_rd && mem_addr == $past(mem_addr, 3) + 16'h0001) else $error("register test length wrong");
  test_nowr_a:
    assert property (fet && mem_rdata[3:0] == TEST_COL && mem_rdata[7:4] inside {[4'h3:4'h7]}
      |-> ##1 !mem_wr [*4]) else $error("test wrote memory");
  full_addr_a:
    assert property (fet && mem_rdata == 8'hC0 |-> ##3 mem_rd && mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)}
      ##1 mem_rd && mem_addr == $past(mem_addr, 4) + 16'h0003) else $error("full address operand wrong");
  bit_dir_a:
    assert property (fet && mem_rdata[7:4] == ROW_BITBR |-> ##3 mem_rd && mem_addr == {8'h00, $past(mem_rdata, 2)})
      else $error("bit branch operand address wrong");
  pause_in_a:
    assert property (fet && mem_rdata == OPC_PAUSE |-> ##2 cpu_halted && !mem_rd) else $error("pause not entered");
  pause_hold_a:
    assert property (cpu_halted && !wake_irq |=> cpu_halted) else $error("pause left without wake");
  pause_wake_a:
    assert property (cpu_halted && wake_irq |=> !cpu_halted && mem_rd) else $error("no fetch after wake");
endmodule
bind cis_core cis_core_sva i_cis_core_sva (.mclk(mclk), .sys_rst(sys_rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wake_irq(wake_irq), .cpu_halted(cpu_halted),
  .core_busy(core_busy));
`default_nettype wire

/* test/testbench.sv */
// Purpose: self-checking bench for the subset execution core
// Assumes: asynchronous-read byte memory, one AHB-Lite master, fixed seed
// Notes: each run loads one instruction at 0x0400 followed by an illegal opcode that stops the core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cis_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, hresp, hreadyout, wake_irq = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, hc = 3'h0;
  logic [15:0] mem_addr, pe = 16'h0;
  logic mem_rd, mem_wr, cpu_halted, core_busy;
  logic [7:0] mem_wdata, mem [65536];
  logic [7:0] opl [17] = '{8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'hF0, 8'h3D, 8'h4D, 8'h5D, 8'h6D, 8'h7D,
    8'h97, 8'h9F, 8'h83, 8'h8F, 8'h00, 8'h01};
  logic [7:0] ra [8] = '{REG_ACC, REG_INDEX, REG_FLAGS, REG_PC, REG_SP, REG_VEC, REG_CTRL, 8'h20};
  logic [31:0] rv [8] = '{32'h0, 32'h0, {24'h0, FLAGS_RST}, 32'h0, {16'h0, SP_RST}, {16'h0, VEC_RST}, 32'h0, 32'h0};
  integer seed = 32'h10DFC8EF;
  int errors = 0, checks = 0, cyc = 0, t0 = -1, t1 = -1;
  wire logic [7:0] mem_rdata = mem[mem_addr];
  cis_core i_cis_core (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .wake_irq(wake_irq), .cpu_halted(cpu_halted), .core_busy(core_busy));
  always #2.5 mclk = ~mclk;
  // memory write port, and a one-cycle wake after six paused cycles
  always @(posedge mclk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    hc <= cpu_halted ? hc + 3'h1 : 3'h0;
    wake_irq <= cpu_halted && hc == 3'h5;
  end
  // fetch times of the loaded instruction and of the one after it
  always @(negedge mclk) begin
    cyc++;
    if (mem_rd && core_busy && mem_addr == 16'h0400 && t0 < 0) t0 = cyc;
    if (mem_rd && core_busy && mem_addr == pe && t1 < 0) t1 = cyc;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkc(input int g, input int e);
    checks++;
    if (g != e) begin
      errors++;
      $display("MISMATCH at %0t: cycles %0d expected %0d", $time, g, e);
    end
  endtask
  // single transfer; ready and read data are taken at the rising edge itself, before the flops move
  // the leading edge keeps the first request out of the edge that releases reset
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= w ? d : $random(seed);
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // total cycles of one instruction, fetch included; zero where it is not fixed
  function automatic int ecyc(input logic [7:0] op);
    case (op)
      8'h97, 8'h9F, 8'hA0: return 2;
      8'hB0, 8'hF0, 8'h4D, 8'h5D: return 3;
      8'hC0, 8'hE0, 8'h3D, 8'h7D: return 4;
      8'hD0, 8'h6D, 8'h00, 8'h01: return 5;
      8'h83: return 10;
      default: return 0;
    endcase
  endfunction
  // operand bytes stay in 0x10-0x2F so they never look like an opcode the checker watches
  task automatic exec(input logic [7:0] op);
    logic [7:0] a, x, f, m, o1, o2, b1, b2, v, ka, kx, kf;
    logic [8:0] r;
    logic [15:0] ea;
    logic [31:0] q;
    logic [39:0] stk;
    int len, n;
    a = 8'($random(seed));
    x = 8'($random(seed));
    m = 8'($random(seed));
    f = {4'hE, 4'($random(seed))};
    o1 = 8'h10 + 8'($random(seed) & 31);
    o2 = 8'h10 + 8'($random(seed) & 31);
    {b1, b2, len, ea} = {o1, o2, 32'd2, 8'h00, o1};
    case (op[7:4])
      4'h0: len = 3;
      4'hC: {len, b1, b2, ea} = {32'd3, 8'h12, o1, 8'h12, o1};
      4'hD: {len, b1, b2, ea} = {32'd3, 8'h11, o1, 16'h1100 + {8'h00, o1} + {8'h00, x}};
      4'hE, 4'h6: ea = {8'h00, o1} + {8'h00, x};
      4'hF, 4'h7: {len, ea} = {32'd1, 8'h00, x};
      4'h4, 4'h5, 4'h8, 4'h9: len = 1;
      default: ;
    endcase
    if (op[7:4] == 4'hA) m = o1;
    else mem[ea] = m;
    v = op == 8'h4D ? a : op == 8'h5D ? x : m;
    mem[16'h0400] = op;
    mem[16'h0401] = b1;
    mem[16'h0402] = b2;
    pe = 16'h0400 + 16'(len);
    if (op[7:4] == ROW_BITBR && m[0] != op[0]) pe = pe + {8'h00, o2};
    if (op == OPC_TRAP) pe = 16'h0500;
    mem[pe] = 8'h42;
    mem[16'h0300] = 8'h05;
    mem[16'h0301] = 8'h00;
    r = {1'b0, a} - {1'b0, m};
    {ka, kx, kf} = {a, x, f};
    if (op[3:0] == SUB_COL && op[7]) {ka, kf[2:0]} = {r[7:0], r[7], r[7:0] == 8'h00, r[8]};
    if (op[3:0] == TEST_COL) kf[2:1] = {v[7], v == 8'h00};
    if (op[7:4] == ROW_BITBR) kf[0] = m[0];
    if (op == OPC_ACC_TO_INDEX) kx = a;
    if (op == OPC_INDEX_TO_ACC) ka = x;
    if (op == OPC_TRAP) kf[3] = 1'b1;
    if (op == OPC_PAUSE) kf[3] = 1'b0;
    stk = {8'h01, 8'h04, x, a, f};
    wr(REG_ACC, {24'h0, a});
    wr(REG_INDEX, {24'h0, x});
    wr(REG_FLAGS, {24'h0, f});
    wr(REG_PC, 32'h0400);
    wr(REG_SP, 32'h03FF);
    wr(REG_VEC, 32'h0300);
    t0 = -1;
    t1 = -1;
    wr(REG_CTRL, 32'h1);
    for (n = 0; core_busy !== 1'b1 && n < 20; n++) @(negedge mclk);
    for (n = 0; core_busy === 1'b1 && n < 3000; n++) @(negedge mclk);
    chkc(int'(n < 3000), 1);
    bus(1'b0, REG_ACC, 32'h0, q);
    chk(q, {24'h0, ka});
    bus(1'b0, REG_INDEX, 32'h0, q);
    chk(q, {24'h0, kx});
    bus(1'b0, REG_FLAGS, 32'h0, q);
    chk(q & 32'hEF, {24'h0, kf});
    bus(1'b0, REG_PC, 32'h0, q);
    chk(q, {16'h0, pe + 16'h0001});
    bus(1'b0, REG_SP, 32'h0, q);
    chk(q, op == OPC_TRAP ? 32'h03FA : 32'h03FF);
    // the stopping opcode lands in status with the error bit, and a write of one clears that bit
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(q, (32'h42 << STAT_OPC_LSB) | (32'h1 << STAT_ERR));
    wr(REG_STATUS, 32'h1 << STAT_ERR);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h42 << STAT_OPC_LSB);
    if (op[3:0] == TEST_COL) chk({24'h0, mem[ea]}, {24'h0, m});
    if (op == OPC_TRAP) for (int i = 0; i < 5; i++) chk(mem[16'h03FF - 16'(i)], stk[39 - 8 * i -: 8]);
    if (ecyc(op) > 0) chkc(t1 - t0, ecyc(op));
    $display("test op %h done after %0d busy cycles", op, n);
  endtask
  // reset values and an unmapped read, then every opcode in opl four times with random state
  initial begin
    logic [31:0] q;
    foreach (mem[i]) mem[i] = 8'h42;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 32'h0, q);
      chk(q, rv[i]);
    end
    $display("test reset values done");
    for (int k = 0; k < 4; k++) foreach (opl[j]) exec(opl[j]);
    tally_and_finish;
  end
  // about seventy runs of well under a hundred cycles each; far beyond that is a hang
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
